// *** rto_pkg.sv ***
// Behaviour
// - one shared signed offset is added to each selected remote channel result.
// - offset is two's complement, sign bit 7, LSB 0.25 degrees, span 31.75.
// - select bits 0..6 enable channels 1..7; bit 7 unused, reads zero.
// - with extended range low, result never goes below code 00h.
// - with extended range high, result never goes above code 7FFh.
// - offset and select registers are zero after reset.
// - open or shorted diode channel shows a fault and is skipped.
// - slave address bits A7..A1 are 1001101, A0 is read/write.
package rto_pkg;

  // register map
  localparam logic [7:0]  REG_OFFSET  = 8'h4D;
  localparam logic [7:0]  REG_ENABLE  = 8'h4E;
  localparam logic [7:0]  REG_FAULT   = 8'h5F;
  localparam logic [7:0]  OFFSET_RST  = 8'h00;
  localparam logic [7:0]  ENABLE_RST  = 8'h00;
  localparam logic [7:0]  ENABLE_MASK = 8'h7F;
  localparam logic [6:0]  FAULT_RST   = 7'h00;

  // serial address and result code limits
  localparam logic [6:0]  SLAVE_ADDR  = 7'h4D;
  localparam int          NUM_CH      = 7;
  localparam logic [2:0]  CH_FIRST    = 3'h1;
  localparam logic [2:0]  CH_LAST     = 3'h7;
  localparam logic [10:0] CODE_MIN    = 11'h000;
  localparam logic [10:0] CODE_MAX    = 11'h7FF;
  localparam logic [3:0]  ACK_BIT     = 4'h8;
  localparam logic [3:0]  LAST_BIT    = 4'h7;

  // register contents as carried into the datapath
  typedef struct packed {
    logic [7:0] offset;
    logic [7:0] enable;
  } rto_regs_t;

  // one finished channel result, 0.125 degree per code step
  typedef struct packed {
    logic [2:0]  chan;
    logic [10:0] code;
  } rto_result_t;

  typedef enum {LIDLE, LADDR, LPTR, LWDAT, LRDAT} rto_link_t;

endpackage

// *** rto_offset_adjust.sv ***
`timescale 1ns/1ns
module rto_offset_adjust (
  // core clock and control
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire logic                ce,
  input  wire logic                extendedRangeSelect,
  // serial link, open drain data
  input  wire logic                sclClk,
  input  wire logic                sdaIn,
  output logic                     sdaOut,
  output logic                     sdaOe_n,
  // diode front end status pins
  input  wire logic [6:0]          diodeOpen,
  input  wire logic [6:0]          diodeShort,
  // converter handshake
  output logic                     convStart,
  output logic [2:0]               convChan,
  input  wire logic                convDone,
  input  wire logic [10:0]         convCode,
  // adjusted results and status
  output logic                     resultValid,
  output rto_pkg::rto_result_t     result,
  output logic [6:0]               faultStatus
);

  // link domain state
  rto_pkg::rto_link_t st_r, st_nxt;
  logic [3:0]         bitCnt_r, bitCnt_nxt;
  logic [7:0]         shReg_r, shReg_nxt;
  logic [7:0]         txByte_r, txByte_nxt;
  logic [7:0]         ptr_r, ptr_nxt;
  logic [7:0]         wrAddr_r, wrAddr_nxt;
  logic [7:0]         wrData_r, wrData_nxt;
  logic               wrTgl_r, wrTgl_nxt;
  logic               match_r, match_nxt;
  logic               rw_r, rw_nxt;
  logic               startTgl_r;
  logic               startSeen_r, startSeen_nxt;
  logic               sdaOe_nxt;
  logic [7:0]         newByte;
  logic [22:0]        rdS1_r, rdS2_r;

  // core domain state
  rto_pkg::rto_regs_t regs_r, regs_nxt;
  logic [6:0]         openS1_r, openS2_r, shortS1_r, shortS2_r;
  logic [6:0]         faultLvl;
  logic [6:0]         fault_r, fault_nxt;
  logic               wrS1_r, wrS2_r, wrS3_r;
  logic               busy_r, busy_nxt;
  logic [2:0]         chan_r, chan_nxt;
  logic               start_r, start_nxt;
  logic               resValid_r, resValid_nxt;
  rto_pkg::rto_result_t res_r, res_nxt;
  logic signed [12:0] sum;
  logic               chanEn;

  // open drain: only ever pulls low
  assign sdaOut      = 1'b0;
  assign convStart   = start_r;
  assign convChan    = chan_r;
  assign resultValid = resValid_r;
  assign result      = res_r;
  assign faultStatus = fault_r;

  // start seen as sda falling while scl high; host timing keeps it
  // stable well before the next scl rise, so it is read there directly
  always_ff @(negedge sdaIn or negedge rst_n) begin
    if (!rst_n) begin
      startTgl_r <= 1'b0;
    end else if (sclClk) begin
      startTgl_r <= ~startTgl_r;
    end
  end

  // register read mux from core values synced into this domain
  function automatic logic [7:0] rdMux(input logic [7:0] a,
                                       input logic [22:0] v);
    logic [7:0] d;
    d = 8'h00;
    if (a == rto_pkg::REG_OFFSET) begin
      d = v[22:15];
    end else if (a == rto_pkg::REG_ENABLE) begin
      d = v[14:7];
    end else if (a == rto_pkg::REG_FAULT) begin
      d = {1'b0, v[6:0]};
    end
    return d;
  endfunction

  // link byte engine, sampled on scl rise
  always_comb begin
    st_nxt        = st_r;
    bitCnt_nxt    = bitCnt_r;
    shReg_nxt     = shReg_r;
    txByte_nxt    = txByte_r;
    ptr_nxt       = ptr_r;
    wrAddr_nxt    = wrAddr_r;
    wrData_nxt    = wrData_r;
    wrTgl_nxt     = wrTgl_r;
    match_nxt     = match_r;
    rw_nxt        = rw_r;
    startSeen_nxt = startTgl_r;
    newByte       = {shReg_r[6:0], sdaIn};
    if (startTgl_r != startSeen_r) begin
      st_nxt     = rto_pkg::LADDR;
      bitCnt_nxt = 4'h1;
      shReg_nxt  = {7'h00, sdaIn};
    end else if (st_r != rto_pkg::LIDLE) begin
      if (bitCnt_r != rto_pkg::ACK_BIT) begin
        shReg_nxt  = newByte;
        txByte_nxt = {txByte_r[6:0], 1'b0};
        bitCnt_nxt = bitCnt_r + 4'h1;
      end
      if (bitCnt_r == rto_pkg::LAST_BIT) begin
        case (st_r)
          rto_pkg::LADDR: begin
            match_nxt = (newByte[7:1] == rto_pkg::SLAVE_ADDR);
            rw_nxt    = newByte[0];
          end
          rto_pkg::LPTR: begin
            ptr_nxt = newByte;
          end
          rto_pkg::LWDAT: begin
            wrAddr_nxt = ptr_r;
            wrData_nxt = newByte;
            wrTgl_nxt  = ~wrTgl_r;
            ptr_nxt    = ptr_r + 8'h01;
          end
          default: begin
          end
        endcase
      end
      if (bitCnt_r == rto_pkg::ACK_BIT) begin
        bitCnt_nxt = 4'h0;
        case (st_r)
          rto_pkg::LADDR: begin
            if (!match_r) begin
              st_nxt = rto_pkg::LIDLE;
            end else if (rw_r) begin
              st_nxt     = rto_pkg::LRDAT;
              txByte_nxt = rdMux(ptr_r, rdS2_r);
            end else begin
              st_nxt = rto_pkg::LPTR;
            end
          end
          rto_pkg::LPTR: begin
            st_nxt = rto_pkg::LWDAT;
          end
          rto_pkg::LRDAT: begin
            // host ack keeps reading, nack ends the transfer
            if (sdaIn) begin
              st_nxt = rto_pkg::LIDLE;
            end else begin
              ptr_nxt    = ptr_r + 8'h01;
              txByte_nxt = rdMux(ptr_r + 8'h01, rdS2_r);
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // link state registers; scl may be still at reset, so async clear
  always_ff @(posedge sclClk or negedge rst_n) begin
    if (!rst_n) begin
      st_r        <= rto_pkg::LIDLE;
      bitCnt_r    <= 4'h0;
      shReg_r     <= 8'h00;
      txByte_r    <= 8'h00;
      ptr_r       <= 8'h00;
      wrAddr_r    <= 8'h00;
      wrData_r    <= 8'h00;
      wrTgl_r     <= 1'b0;
      match_r     <= 1'b0;
      rw_r        <= 1'b0;
      startSeen_r <= 1'b0;
      rdS1_r      <= 23'h000000;
      rdS2_r      <= 23'h000000;
    end else begin
      st_r        <= st_nxt;
      bitCnt_r    <= bitCnt_nxt;
      shReg_r     <= shReg_nxt;
      txByte_r    <= txByte_nxt;
      ptr_r       <= ptr_nxt;
      wrAddr_r    <= wrAddr_nxt;
      wrData_r    <= wrData_nxt;
      wrTgl_r     <= wrTgl_nxt;
      match_r     <= match_nxt;
      rw_r        <= rw_nxt;
      startSeen_r <= startSeen_nxt;
      rdS1_r      <= {regs_r, fault_r};
      rdS2_r      <= rdS1_r;
    end
  end

  // data pin changes on scl fall: ack slots and read bits
  always_comb begin
    sdaOe_nxt = 1'b1;
    if (bitCnt_r == rto_pkg::ACK_BIT) begin
      if ((st_r == rto_pkg::LADDR && match_r) ||
          st_r == rto_pkg::LPTR || st_r == rto_pkg::LWDAT) begin
        sdaOe_nxt = 1'b0;
      end
    end else if (st_r == rto_pkg::LRDAT) begin
      sdaOe_nxt = txByte_r[7];
    end
  end

  always_ff @(negedge sclClk or negedge rst_n) begin
    if (!rst_n) begin
      sdaOe_n <= 1'b1;
    end else begin
      sdaOe_n <= sdaOe_nxt;
    end
  end

  // per channel fault level, open or shorted diode pair
  for (genvar g = 0; g < rto_pkg::NUM_CH; g++) begin : gFault
    assign faultLvl[g] = openS2_r[g] | shortS2_r[g];
  end

  // next healthy channel after cur, wrapping 7 back to 1
  function automatic logic [2:0] nextChan(input logic [2:0] cur,
                                          input logic [6:0] flt);
    logic [2:0] c;
    logic [2:0] r;
    logic       found;
    c     = cur;
    r     = cur;
    found = 1'b0;
    for (int i = 0; i < rto_pkg::NUM_CH; i++) begin
      c = (c == rto_pkg::CH_LAST) ? rto_pkg::CH_FIRST : c + 3'h1;
      if (!found && !flt[c - 3'h1]) begin
        r     = c;
        found = 1'b1;
      end
    end
    return r;
  endfunction

  // offset applied at twice weight: offset LSB is two code steps
  assign chanEn = regs_r.enable[chan_r - 3'h1];
  assign sum    = $signed({2'b00, convCode}) +
                  (chanEn ? $signed({{4{regs_r.offset[7]}},
                                     regs_r.offset, 1'b0})
                          : 13'sh0000);

  // register writes, sequencer and result stage
  always_comb begin
    regs_nxt     = regs_r;
    fault_nxt    = faultLvl;
    busy_nxt     = busy_r;
    chan_nxt     = chan_r;
    start_nxt    = 1'b0;
    resValid_nxt = 1'b0;
    res_nxt      = res_r;
    if (wrS2_r != wrS3_r) begin
      if (wrAddr_r == rto_pkg::REG_OFFSET) begin
        regs_nxt.offset = wrData_r;
      end else if (wrAddr_r == rto_pkg::REG_ENABLE) begin
        regs_nxt.enable = wrData_r & rto_pkg::ENABLE_MASK;
      end
    end
    if (!busy_r) begin
      // all channels faulted leaves the sequencer idle
      if (faultLvl != 7'h7F) begin
        chan_nxt  = nextChan(chan_r, faultLvl);
        start_nxt = 1'b1;
        busy_nxt  = 1'b1;
      end
    end else if (convDone) begin
      busy_nxt     = 1'b0;
      resValid_nxt = 1'b1;
      res_nxt.chan = chan_r;
      if (sum < 13'sh0000) begin
        res_nxt.code = rto_pkg::CODE_MIN;
      end else if (sum > $signed({2'b00, rto_pkg::CODE_MAX})) begin
        res_nxt.code = rto_pkg::CODE_MAX;
      end else begin
        res_nxt.code = sum[10:0];
      end
    end
  end

  // core registers, synchronous reset, otherwise frozen while ce is low
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      regs_r     <= '{offset: rto_pkg::OFFSET_RST,
                      enable: rto_pkg::ENABLE_RST};
      fault_r    <= rto_pkg::FAULT_RST;
      openS1_r   <= 7'h00;
      openS2_r   <= 7'h00;
      shortS1_r  <= 7'h00;
      shortS2_r  <= 7'h00;
      wrS1_r     <= 1'b0;
      wrS2_r     <= 1'b0;
      wrS3_r     <= 1'b0;
      busy_r     <= 1'b0;
      chan_r     <= rto_pkg::CH_LAST;
      start_r    <= 1'b0;
      resValid_r <= 1'b0;
      res_r      <= '0;
    end else if (ce) begin
      regs_r     <= regs_nxt;
      fault_r    <= fault_nxt;
      openS1_r   <= diodeOpen;
      openS2_r   <= openS1_r;
      shortS1_r  <= diodeShort;
      shortS2_r  <= shortS1_r;
      wrS1_r     <= wrTgl_r;
      wrS2_r     <= wrS1_r;
      wrS3_r     <= wrS2_r;
      busy_r     <= busy_nxt;
      chan_r     <= chan_nxt;
      start_r    <= start_nxt;
      resValid_r <= resValid_nxt;
      res_r      <= res_nxt;
    end
  end

  // extended range select is held static by config logic
  sequence s_conv;
    ce && busy_r && convDone;
  endsequence

  property p_offsetAdd;
    @(posedge ref_clk) disable iff (!rst_n)
    s_conv ##0 (sum >= 13'sh0000 && sum <= 13'sh07FF)
    |=> resValid_r && $past(sum) == $signed({2'b00, res_r.code});
  endproperty
  a_offsetAdd: assert property (p_offsetAdd)
    else $error("offset sum not reported");

  property p_offsetSign;
    @(posedge ref_clk) disable iff (!rst_n)
    s_conv ##0 (chanEn && regs_r.offset[7] && convCode != 11'h000)
    |=> res_r.code < $past(convCode);
  endproperty
  a_offsetSign: assert property (p_offsetSign)
    else $error("negative offset did not lower result");

  property p_noOffset;
    @(posedge ref_clk) disable iff (!rst_n)
    s_conv ##0 !chanEn |=> res_r.code == $past(convCode);
  endproperty
  a_noOffset: assert property (p_noOffset)
    else $error("offset applied to unselected channel");

  property p_clampLow;
    @(posedge ref_clk) disable iff (!rst_n)
    s_conv ##0 (!extendedRangeSelect && sum < 13'sh0000)
    |=> res_r.code == 11'h000;
  endproperty
  a_clampLow: assert property (p_clampLow)
    else $error("result not held at bottom code");

  property p_clampHigh;
    @(posedge ref_clk) disable iff (!rst_n)
    s_conv ##0 (extendedRangeSelect && sum > 13'sh07FF)
    |=> res_r.code == 11'h7FF;
  endproperty
  a_clampHigh: assert property (p_clampHigh)
    else $error("result not held at top code");

  property p_resetZero;
    @(posedge ref_clk) !rst_n |=> regs_r == 16'h0000 && !start_r;
  endproperty
  a_resetZero: assert property (p_resetZero)
    else $error("registers not cleared by reset");

  property p_skipFault;
    @(posedge ref_clk) disable iff (!rst_n)
    ce && !busy_r && faultLvl != 7'h7F
    |=> start_r &&
        (($past(faultLvl) >> (chan_r - 3'h1)) & 7'h01) == 7'h00;
  endproperty
  a_skipFault: assert property (p_skipFault)
    else $error("faulted channel was measured");

  property p_faultShow;
    @(posedge ref_clk) disable iff (!rst_n)
    (ce && (diodeOpen[2] || diodeShort[2]))[*3]
    |=> fault_r[2];
  endproperty
  a_faultShow: assert property (p_faultShow)
    else $error("diode fault not reported");

  property p_ackMatch;
    @(posedge sclClk) disable iff (!rst_n)
    st_r == rto_pkg::LADDR && bitCnt_r == 4'h8
    |-> (!sdaOe_n) == (shReg_r[7:1] == 7'h4D);
  endproperty
  a_ackMatch: assert property (p_ackMatch)
    else $error("address ack does not follow address");

endmodule

// *** rto_host_model.sv ***
`timescale 1ns/1ns
module rto_host_model (
  // serial link toward the device
  output logic      sclClk,
  output logic      sdaLow,
  input  wire logic sdaLine
);
  // clock stands high and data is released between frames
  initial begin
    sclClk = 1'b1;
    sdaLow = 1'b0;
  end

  // data changes only while the clock is low
  task automatic bitOut(input logic b);
    sdaLow = ~b;
    #31 sclClk = 1'b1;
    #63 sclClk = 1'b0;
    #31;
  endtask

  // sample just after the rise, the device changes on the fall
  task automatic bitIn(output logic b);
    sdaLow = 1'b0;
    #31 sclClk = 1'b1;
    #2 b = sdaLine;
    #61 sclClk = 1'b0;
    #31;
  endtask

  // start and repeated start alike
  task automatic startCond();
    sdaLow = 1'b0;
    #31 sclClk = 1'b1;
    #31 sdaLow = 1'b1;
    #31 sclClk = 1'b0;
    #31;
  endtask

  task automatic stopCond();
    sdaLow = 1'b1;
    #31 sclClk = 1'b1;
    #31 sdaLow = 1'b0;
    #31;
  endtask

  // msb first, then the ninth clock for the acknowledge
  task automatic byteOut(input logic [7:0] v, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bitOut(v[i]);
    end
    bitIn(a);
    ack = ~a;
  endtask

  task automatic writeReg(input logic [6:0] dev, input logic [7:0] ptr,
                          input logic [7:0] dat, output logic acked);
    logic a0;
    logic a1;
    logic a2;
    startCond();
    byteOut({dev, 1'b0}, a0);
    byteOut(ptr, a1);
    byteOut(dat, a2);
    stopCond();
    acked = a0 & a1 & a2;
  endtask

  // pointer write, repeated start, one byte read, then nack
  task automatic readReg(input logic [6:0] dev, input logic [7:0] ptr,
                         output logic [7:0] dat);
    logic a;
    startCond();
    byteOut({dev, 1'b0}, a);
    byteOut(ptr, a);
    startCond();
    byteOut({dev, 1'b1}, a);
    for (int i = 7; i >= 0; i--) begin
      bitIn(dat[i]);
    end
    bitOut(1'b1);
    stopCond();
  endtask
endmodule

// *** rto_offset_adjust_tb_top.sv ***
`timescale 1ns/1ns
module rto_offset_adjust_tb_top;
  localparam logic [6:0] DEV = 7'b1001101;
  // stimulus and observed signals
  logic                 ref_clk, rst_n, ce, extendedRangeSelect;
  logic                 sclClk, sdaLow, sdaLine, sdaOut, sdaOe_n;
  logic                 convStart, convDone, resultValid, chkOn, hit;
  logic [6:0]           diodeOpen, diodeShort, faultStatus;
  logic [2:0]           convChan, chanHeld;
  logic [10:0]          convCode, codeBase, sentCode, expCode;
  logic [7:0]           offSh, enSh;
  rto_pkg::rto_result_t result;
  int                   busyCnt, nRes, fails, n_checks;

  // open-drain data line with pull-up
  assign sdaLine = (sdaLow || sdaOe_n === 1'b0) ? 1'b0 : 1'b1;

  rto_offset_adjust rto_offset_adjust_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .ce(ce), .extendedRangeSelect(extendedRangeSelect), .sclClk(sclClk),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n),
    .diodeOpen(diodeOpen), .diodeShort(diodeShort), .convStart(convStart),
    .convChan(convChan), .convDone(convDone), .convCode(convCode),
    .resultValid(resultValid), .result(result), .faultStatus(faultStatus));

  rto_host_model rto_host_model_i (.sclClk(sclClk), .sdaLow(sdaLow),
    .sdaLine(sdaLine));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // both ends clamp, so the expectation does not depend on the mode
  function automatic logic [10:0] adj(input logic [10:0] c,
                                      input logic [2:0] ch);
    int s;
    s = int'(c);
    if (enSh[ch - 3'h1]) s = s + 2 * int'($signed(offSh));
    if (s < 0) s = 0;
    if (s > 2047) s = 2047;
    return s[10:0];
  endfunction

  // converter stand-in and result monitor; monitor runs first
  always @(negedge ref_clk) begin
    if (resultValid === 1'b1) begin
      nRes = nRes + 1;
      expCode = adj(sentCode, chanHeld);
      if (chkOn) begin
        check("chan", 16'(result.chan), 16'(chanHeld));
        check("code", 16'(result.code), 16'(expCode));
      end
    end
    convDone = 1'b0;
    convCode = ~convCode; // no stale code outside the done pulse
    if (convStart === 1'b1) begin
      chanHeld = convChan;
      busyCnt = 3;
    end else if (busyCnt > 0) begin
      busyCnt = busyCnt - 1;
      if (busyCnt == 0) begin
        sentCode = codeBase + 11'(chanHeld);
        convCode = sentCode;
        convDone = 1'b1;
      end
    end
  end

  task automatic waitResults(input int n);
    int t;
    t = 0;
    nRes = 0;
    while (nRes < n && t < 2000) begin
      @(negedge ref_clk);
      t = t + 1;
    end
    if (nRes < n) begin
      fails = fails + 1;
      $display("unexpected timeout waiting for results");
      test_done();
    end
  endtask

  // program both registers, read them back, flush results in flight
  task automatic setRegs(input logic [7:0] off, en);
    logic       ok;
    logic [7:0] rd;
    chkOn = 1'b0;
    rto_host_model_i.writeReg(DEV, 8'h4D, off, ok);
    check("ack", 16'(ok), 16'h0001);
    rto_host_model_i.writeReg(DEV, 8'h4E, en, ok);
    rto_host_model_i.readReg(DEV, 8'h4D, rd);
    check("offset reg", 16'(rd), 16'(off));
    rto_host_model_i.readReg(DEV, 8'h4E, rd);
    check("enable reg", 16'(rd), 16'(en & 8'h7F));
    offSh = off;
    enSh = en;
    waitResults(2);
    chkOn = 1'b1;
  endtask

  task automatic scReset();
    logic [7:0] rd;
    rto_host_model_i.readReg(DEV, 8'h4D, rd);
    check("offset rst", 16'(rd), 16'h0000);
    rto_host_model_i.readReg(DEV, 8'h4E, rd);
    check("enable rst", 16'(rd), 16'h0000);
    check("fault rst", 16'(faultStatus), 16'h0000);
    check("sda out", 16'(sdaOut), 16'h0000);
  endtask

  // a near-miss address must be ignored entirely
  task automatic scAddress();
    logic       ok;
    logic [7:0] rd;
    rto_host_model_i.writeReg(7'b1001100, 8'h4D, 8'h55, ok);
    check("foreign ack", 16'(ok), 16'h0000);
    rto_host_model_i.readReg(DEV, 8'h4D, rd);
    check("offset kept", 16'(rd), 16'h0000);
  endtask

  // top weight on alternate channels, then the smallest negative step
  task automatic scArith();
    @(negedge ref_clk);
    extendedRangeSelect = 1'b0;
    codeBase = 11'h100;
    setRegs(8'h7F, 8'h55);
    waitResults(14);
    setRegs(8'hFF, 8'hFF);
    waitResults(7);
  endtask

  task automatic scClamp(input logic ext, input logic [10:0] base,
                         input logic [7:0] off, input logic [10:0] lim);
    @(negedge ref_clk);
    extendedRangeSelect = ext;
    codeBase = base;
    setRegs(off, 8'h7F);
    waitResults(7);
    check("clamp", 16'(result.code), 16'(lim));
    chkOn = 1'b0;
  endtask

  // one open and one shorted channel must drop out of the sequence
  task automatic scFault();
    @(negedge ref_clk);
    // faulted channels stand in for unused ones; no alarms here
    diodeOpen = 7'h04;
    diodeShort = 7'h10;
    repeat (8) @(negedge ref_clk);
    check("fault", 16'(faultStatus), 16'h0014);
    for (int k = 0; k < 200; k++) begin
      @(negedge ref_clk);
      hit = (convChan == 3'h3) || (convChan == 3'h5);
      if (convStart === 1'b1) begin
        check("skip", 16'(hit), 16'h0000);
      end
    end
    diodeOpen = 7'h00;
    diodeShort = 7'h00;
  endtask

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    extendedRangeSelect = 1'b0;
    diodeOpen = 7'h00;
    diodeShort = 7'h00;
    convDone = 1'b0;
    convCode = 11'h000;
    codeBase = 11'h100;
    sentCode = 11'h000;
    chanHeld = 3'h1;
    offSh = 8'h00;
    enSh = 8'h00;
    chkOn = 1'b0;
    busyCnt = 0;
    nRes = 0;
    fails = 0;
    n_checks = 0;
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    scReset();
    scAddress();
    scArith();
    scClamp(1'b1, 11'h7F0, 8'h7F, 11'h7FF);
    scClamp(1'b0, 11'h010, 8'h80, 11'h000);
    scFault();
    test_done();
  end
endmodule
